// ### hw/ccm_clock_mode_config.sv
// Clock mode sampling, mode and control registers, and derived clocks.
`include "ccm_cfg.svh"
module ccm_clock_mode_config
#(
    parameter ccm_pkg::ccm_mode_table_type MODE_TABLE = '{default: `CCM_MODE_DEFAULT}
)
(
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Mode straps
    input wire logic [2:0] clockModePins,
    input wire logic [2:0] clockModeHighBits,
    // Register port
    input wire logic [`CCM_ADDR_W-1:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData_r,
    output logic regRdAck_r,
    // Mode controls to the PLLs, DLL and dividers
    output logic [3:0] corePllPrediv_r,
    output logic [3:0] corePllMult_r,
    output logic [3:0] busDivide_r,
    output logic [3:0] commProcDivide_r,
    output logic [3:0] sysPllPrediv_r,
    output logic [3:0] sysPllMult_r,
    output logic dllDisable_r,
    output logic [3:0] coreDivide_r,
    output logic modeValid_r,
    // Derived clocks
    output logic baudGenClock_r,
    output logic serialCtrlClock_r,
    output logic clockOutput_r
);
    import ccm_pkg::*;

    ccm_state_type state_r;
    ccm_state_type state_nxt;
    ccm_word_type modeReg_r;
    ccm_word_type modeWord;
    logic [1:0] baudClockDivide_r;
    logic clockOutDisable_r;
    ccm_div_if divIf ();

    function automatic ccm_word_type ctrlImage(input logic [1:0] baud, input logic dis);
        ccm_word_type w;
        w = 32'h00000000;
        w[`CCM_BAUD_DIV_LSB +: 2] = baud;
        w[`CCM_CLKO_DIS_BIT] = dis;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    ccm_mode_rom #(.MODE_TABLE(MODE_TABLE)) modeRom
    (
        .modeSel({clockModeHighBits, clockModePins}),
        .modeWord(modeWord)
    );

    ccm_clk_div clkDiv
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .divIf(divIf.div)
    );

    assign divIf.baudSel = baudClockDivide_r;

    ////////////////////////////////////////////////////////////////////////
    // The straps are caught by a clocked step after release, never by the
    // asynchronous reset itself, so no port value enters a reset branch.
    always_comb
    begin
        case (state_r)
            CCM_ST_RESET: state_nxt = CCM_ST_SAMPLE;
            CCM_ST_SAMPLE: state_nxt = CCM_ST_RUN;
            CCM_ST_RUN: state_nxt = CCM_ST_RUN;
            default: state_nxt = CCM_ST_RESET;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= CCM_ST_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only the first edge after power-on release loads the mode; nothing later
    // reloads it, so the mode holds untouched until rst_b falls again.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            modeReg_r <= `CCM_MODE_RESET;
            modeValid_r <= 1'h0;
        end
        else if (state_r == CCM_ST_RESET)
        begin
            modeReg_r <= modeWord;
            modeValid_r <= 1'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            corePllPrediv_r <= 4'h0;
            corePllMult_r <= 4'h0;
            busDivide_r <= 4'h0;
            commProcDivide_r <= 4'h0;
            sysPllPrediv_r <= 4'h0;
            sysPllMult_r <= 4'h0;
            dllDisable_r <= 1'h0;
            coreDivide_r <= 4'h0;
        end
        else
        begin
            corePllPrediv_r <= modeReg_r[`CCM_CORE_PDF_LSB +: `CCM_FIELD_W];
            corePllMult_r <= modeReg_r[`CCM_CORE_MF_LSB +: `CCM_FIELD_W];
            busDivide_r <= modeReg_r[`CCM_BUS_DF_LSB +: `CCM_FIELD_W];
            commProcDivide_r <= modeReg_r[`CCM_CPM_DF_LSB +: `CCM_FIELD_W];
            sysPllPrediv_r <= modeReg_r[`CCM_SPLL_PDF_LSB +: `CCM_FIELD_W];
            sysPllMult_r <= modeReg_r[`CCM_SPLL_MF_LSB +: `CCM_FIELD_W];
            dllDisable_r <= modeReg_r[`CCM_DLL_DIS_BIT];
            coreDivide_r <= modeReg_r[`CCM_CORE_DF_LSB +: `CCM_FIELD_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reserved bits are not stored, so a non-zero write there is dropped.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baudClockDivide_r <= `CCM_BAUD_DIV_RESET;
            clockOutDisable_r <= `CCM_CLKO_DIS_RESET;
        end
        else if (regWr && regAddr == `CCM_CTRL_OFFSET)
        begin
            baudClockDivide_r <= regWrData[`CCM_BAUD_DIV_LSB +: 2];
            clockOutDisable_r <= regWrData[`CCM_CLKO_DIS_BIT];
        end
    end

    // Writes to the mode register address have no effect.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdData_r <= 32'h00000000;
            regRdAck_r <= 1'h0;
        end
        else
        begin
            regRdAck_r <= regRd;
            if (regRd && regAddr == `CCM_CTRL_OFFSET)
            begin
                regRdData_r <= ctrlImage(baudClockDivide_r, clockOutDisable_r);
            end
            else if (regRd && regAddr == `CCM_MODE_OFFSET)
            begin
                regRdData_r <= modeReg_r;
            end
            else
            begin
                regRdData_r <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The disabled output parks low; any level would be legal there.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clockOutput_r <= 1'h0;
            baudGenClock_r <= 1'h0;
            serialCtrlClock_r <= 1'h0;
        end
        else
        begin
            clockOutput_r <= clockOutDisable_r ? 1'h0 : ~clockOutput_r;
            baudGenClock_r <= divIf.baudClk;
            serialCtrlClock_r <= divIf.sccClk;
        end
    end
endmodule // ccm_clock_mode_config

// ### pkg/ccm_cfg.svh
// Constants of the clock mode configuration block.
// Contract
// - Mode selection is six bits: three mode pins plus three configuration word bits.
// - Pins and configuration bits are sampled when power-on reset is released.
// - Clock configuration changes only at power-on reset release, held otherwise.
// - Sampled mode sets seven PLL and divider factors.
// - Serial controller clock divider is fixed at divide by four.
// - Baud divide field bits 30-31 selects 4/16/64/256, resets to 01.
// - Changing baud divide never disturbs PLL lock.
// - Bit 27 disables clock output when set, resets to 0.
// - Mode register is read-only, loaded at power-on reset, drives clock logic.
// - Mode register at 0x10C88 holds the eight documented fields.
// - DLL disable bit keeps DLL running at 0, disables at 1.
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH

`define CCM_ADDR_W 20
`define CCM_CTRL_OFFSET 20'h10C80
`define CCM_MODE_OFFSET 20'h10C88

`define CCM_CORE_PDF_LSB 0
`define CCM_CORE_MF_LSB 4
`define CCM_BUS_DF_LSB 8
`define CCM_CPM_DF_LSB 12
`define CCM_SPLL_PDF_LSB 16
`define CCM_SPLL_MF_LSB 20
`define CCM_DLL_DIS_BIT 25
`define CCM_CORE_DF_LSB 28
`define CCM_FIELD_W 4

`define CCM_CLKO_DIS_BIT 27
`define CCM_BAUD_DIV_LSB 30
`define CCM_CTRL_WR_MASK 32'hC8000000

`define CCM_BAUD_DIV_RESET 2'h1
`define CCM_CLKO_DIS_RESET 1'h0
`define CCM_MODE_RESET 32'h00000000
`define CCM_MODE_DEFAULT 32'h10050105

`define CCM_BAUD_HALF_4 8'h02
`define CCM_BAUD_HALF_16 8'h08
`define CCM_BAUD_HALF_64 8'h20
`define CCM_BAUD_HALF_256 8'h80
`define CCM_SCC_HALF 2'h2

`endif

// ### pkg/ccm_pkg.sv
// Types of the clock mode configuration block.
package ccm_pkg;
    typedef logic [31:0] ccm_word_type;
    typedef ccm_word_type ccm_mode_table_type [64];
    typedef enum logic [1:0]
    {
        CCM_ST_RESET = 2'h0,
        CCM_ST_SAMPLE = 2'h1,
        CCM_ST_RUN = 2'h3
    } ccm_state_type;
endpackage

// ### pkg/ccm_div_if.sv
// Carrier between the configuration core and the clock divider.
interface ccm_div_if;
    logic [1:0] baudSel;
    logic baudClk;
    logic sccClk;
    modport ctrl (output baudSel, input baudClk, input sccClk);
    modport div (input baudSel, output baudClk, output sccClk);
endinterface

// ### hw/ccm_mode_rom.sv
// Mode table lookup from the six selection bits to a mode register image.
`include "ccm_cfg.svh"
module ccm_mode_rom
#(
    parameter ccm_pkg::ccm_mode_table_type MODE_TABLE = '{default: `CCM_MODE_DEFAULT}
)
(
    // Selection
    input wire logic [5:0] modeSel,
    // Image
    output ccm_pkg::ccm_word_type modeWord
);
    import ccm_pkg::*;

    // Bits 24, 26 and 27 are reserved and never leave the table as ones.
    assign modeWord = MODE_TABLE[modeSel] & 32'hF2FFFFFF;
endmodule // ccm_mode_rom

// ### hw/ccm_clk_div.sv
// Baud generator and serial controller clock dividers.
`include "ccm_cfg.svh"
module ccm_clk_div
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Carrier
    ccm_div_if.div divIf
);
    import ccm_pkg::*;

    logic [7:0] baudCnt_r;
    logic [7:0] baudHalf;
    logic [1:0] sccCnt_r;
    logic baudClk_r;
    logic sccClk_r;

    always_comb
    begin
        case (divIf.baudSel)
            2'h0: baudHalf = `CCM_BAUD_HALF_4;
            2'h1: baudHalf = `CCM_BAUD_HALF_16;
            2'h2: baudHalf = `CCM_BAUD_HALF_64;
            default: baudHalf = `CCM_BAUD_HALF_256;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // A new ratio only retimes this counter; the PLLs never see it, and the
    // compare is >= so a shorter ratio cannot strand the count past its end.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            baudCnt_r <= 8'h00;
            baudClk_r <= 1'h0;
        end
        else if (baudCnt_r >= baudHalf - 8'h01)
        begin
            baudCnt_r <= 8'h00;
            baudClk_r <= ~baudClk_r;
        end
        else
        begin
            baudCnt_r <= baudCnt_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sccCnt_r <= 2'h0;
            sccClk_r <= 1'h0;
        end
        else if (sccCnt_r == `CCM_SCC_HALF - 2'h1)
        begin
            sccCnt_r <= 2'h0;
            sccClk_r <= ~sccClk_r;
        end
        else
        begin
            sccCnt_r <= sccCnt_r + 2'h1;
        end
    end

    assign divIf.baudClk = baudClk_r;
    assign divIf.sccClk = sccClk_r;
endmodule // ccm_clk_div

// ### tb/ccm_clock_mode_checker.sv
// Assertions on the ports of the clock mode configuration block.
`include "ccm_cfg.svh"
module ccm_clock_mode_checker
#(
    parameter ccm_pkg::ccm_mode_table_type MODE_TABLE = '{default: `CCM_MODE_DEFAULT}
)
(
    // Clock and reset
    input logic clk_sys,
    input logic rst_b,
    // Straps
    input logic [2:0] clockModePins,
    input logic [2:0] clockModeHighBits,
    // Register port
    input logic [`CCM_ADDR_W-1:0] regAddr,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regWrData,
    input logic [31:0] regRdData_r,
    input logic regRdAck_r,
    // Mode controls
    input logic [3:0] corePllPrediv_r,
    input logic [3:0] corePllMult_r,
    input logic [3:0] busDivide_r,
    input logic [3:0] commProcDivide_r,
    input logic [3:0] sysPllPrediv_r,
    input logic [3:0] sysPllMult_r,
    input logic dllDisable_r,
    input logic [3:0] coreDivide_r,
    input logic modeValid_r,
    // Derived clocks
    input logic baudGenClock_r,
    input logic serialCtrlClock_r,
    input logic clockOutput_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrlShadow_r;
    logic [31:0] modeImage;
    assign modeImage = {coreDivide_r, 2'h0, dllDisable_r, 1'h0, sysPllMult_r, sysPllPrediv_r,
        commProcDivide_r, busDivide_r, corePllMult_r, corePllPrediv_r};
    // Reserved bits never read back, so the shadow keeps only the writable ones.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            ctrlShadow_r <= 32'h40000000;
        else if (regWr && regAddr == `CCM_CTRL_OFFSET)
            ctrlShadow_r <= regWrData & `CCM_CTRL_WR_MASK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence readCtrl;
        regRd && regAddr == `CCM_CTRL_OFFSET;
    endsequence
    sequence readMode;
        regRd && regAddr == `CCM_MODE_OFFSET;
    endsequence
    sequence readOther;
        regRd && regAddr != `CCM_CTRL_OFFSET && regAddr != `CCM_MODE_OFFSET;
    endsequence
    sequence disHeld;
        ctrlShadow_r[`CCM_CLKO_DIS_BIT] && $past(ctrlShadow_r[`CCM_CLKO_DIS_BIT]);
    endsequence
    sequence modeSettled;
        modeValid_r && $past(modeValid_r, 2);
    endsequence
    sequence sccNextRise;
        !$rose(serialCtrlClock_r) [*3] ##1 $rose(serialCtrlClock_r);
    endsequence
    property modeLoad;
        logic [5:0] idx;
        ($rose(rst_b), idx = {clockModeHighBits, clockModePins})
            |-> ##3 modeImage == (MODE_TABLE[idx] & 32'hF2FFFFFF);
    endproperty
    ////////////////////////////////////////////////////////////////////////////////
    a_read_ack: assert property (regRd |=> regRdAck_r)
        else $error("read not acknowledged");
    a_ctrl_readback: assert property (readCtrl |=> regRdData_r == $past(ctrlShadow_r))
        else $error("control register read mismatch");
    // The field outputs trail the register by one edge, so the read answer
    // lines up with them in the cycle it is presented, even right after release.
    a_mode_readback: assert property (readMode |=> regRdData_r == modeImage)
        else $error("mode register read mismatch");
    a_unmapped_zero: assert property (readOther |=> regRdData_r == 32'h0)
        else $error("unmapped read not zero");
    a_clock_output_off: assert property (disHeld |-> !clockOutput_r)
        else $error("clock output runs while disabled");
    a_mode_load: assert property (modeLoad)
        else $error("mode not loaded from straps");
    a_mode_hold: assert property (modeSettled |-> $stable(modeImage))
        else $error("mode changed after sampling");
    a_scc_period: assert property ($rose(serialCtrlClock_r) |=> sccNextRise)
        else $error("serial clock not divided by four");
endmodule // ccm_clock_mode_checker

bind ccm_clock_mode_config ccm_clock_mode_checker #(.MODE_TABLE(MODE_TABLE)) chk (.*);

// ### tb/ccm_strap_board.sv
// Board straps and reset configuration word source for the mode selection.
module ccm_strap_board
(
    // Chosen mode index
    input logic [5:0] modeSet,
    // Straps
    output logic [2:0] pins,
    output logic [2:0] highBits
);
    // The board only picks indices of the table it was built for, and passes any change of modeSet straight to the straps.
    assign pins = modeSet[2:0];
    assign highBits = modeSet[5:3];
endmodule // ccm_strap_board

// ### tb/tb_ccm_clock_mode_config.sv
// Testbench of the clock mode configuration block.
`include "ccm_cfg.svh"
module tb_ccm_clock_mode_config;
    timeunit 1ns;
    timeprecision 1ns;
    import ccm_pkg::*;
    function automatic ccm_mode_table_type mkTable();
        ccm_mode_table_type t;
        for (int i = 0; i < 64; i++)
            t[i] = {4'(i), 2'h0, 1'(i), 1'h0, 4'(i + 3), 4'(i + 5), 4'(i + 7), 4'(i + 9),
                4'(i + 11), 4'(i + 13)};
        return t;
    endfunction
    localparam ccm_mode_table_type TBL = mkTable();
    localparam logic [19:0] CTRL = `CCM_CTRL_OFFSET;
    localparam logic [19:0] MODE = `CCM_MODE_OFFSET;
    ////////////////////////////////////////////////////////////////////////////////
    logic clk_sys = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0;
    logic [5:0] modeSet = 6'h2D;
    logic [19:0] regAddr = 20'h0;
    logic [31:0] regWrData = 32'h0, regRdData_r, modeOut;
    logic [2:0] clockModePins, clockModeHighBits;
    logic [3:0] corePllPrediv_r, corePllMult_r, busDivide_r, commProcDivide_r;
    logic [3:0] sysPllPrediv_r, sysPllMult_r, coreDivide_r;
    logic regRdAck_r, dllDisable_r, modeValid_r, baudGenClock_r, serialCtrlClock_r, clockOutput_r;
    int miscompares = 0, comparisons = 0;
    assign modeOut = {coreDivide_r, 2'h0, dllDisable_r, 1'h0, sysPllMult_r, sysPllPrediv_r,
        commProcDivide_r, busDivide_r, corePllMult_r, corePllPrediv_r};
    always #50 clk_sys = ~clk_sys;
    ccm_strap_board board (.modeSet, .pins(clockModePins), .highBits(clockModeHighBits));
    ccm_clock_mode_config #(.MODE_TABLE(TBL)) uut (.clk_sys, .rst_b, .clockModePins,
        .clockModeHighBits, .regAddr, .regWr, .regRd, .regWrData, .regRdData_r, .regRdAck_r,
        .corePllPrediv_r, .corePllMult_r, .busDivide_r, .commProcDivide_r, .sysPllPrediv_r,
        .sysPllMult_r, .dllDisable_r, .coreDivide_r, .modeValid_r, .baudGenClock_r,
        .serialCtrlClock_r, .clockOutput_r);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWr = 1'h1;
        @(negedge clk_sys);
        regWr = 1'h0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string what);
        @(negedge clk_sys);
        regAddr = a;
        regRd = 1'h1;
        @(negedge clk_sys);
        regRd = 1'h0;
        chk({31'h0, regRdAck_r}, 32'h1, "read ack");
        chk(regRdData_r, exp, what);
    endtask
    // Counts rising edges of the three derived clocks over a fixed window.
    task automatic cnt(output int b, output int s, output int o);
        logic [2:0] p;
        b = 0;
        s = 0;
        o = 0;
        p = {baudGenClock_r, serialCtrlClock_r, clockOutput_r};
        repeat (512)
        begin
            @(negedge clk_sys);
            b += int'(baudGenClock_r && !p[2]);
            s += int'(serialCtrlClock_r && !p[1]);
            o += int'(clockOutput_r && !p[0]);
            p = {baudGenClock_r, serialCtrlClock_r, clockOutput_r};
        end
    endtask
    task automatic resetFor(input logic [5:0] m);
        @(negedge clk_sys);
        modeSet = m;
        rst_b = 1'h0;
        repeat (3) @(negedge clk_sys);
        rst_b = 1'h1;
        repeat (4) @(negedge clk_sys);
        chk(modeOut, TBL[m], "mode fields");
        chk({31'h0, modeValid_r}, 32'h1, "mode valid");
        rd(CTRL, 32'h40000000, "control reset");
        rd(MODE, TBL[m], "mode read");
    endtask
    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int b, s, o;
        resetFor(6'h2D);
        $display("test reset sampling done");
        modeSet = 6'h12;
        wr(MODE, 32'hFFFFFFFF);
        rd(MODE, TBL[6'h2D], "mode held");
        rd(20'h10C84, 32'h0, "unmapped read");
        // Software keeps reserved control bits at zero, so only the fields are set.
        wr(CTRL, `CCM_CTRL_WR_MASK);
        rd(CTRL, 32'hC8000000, "control writable bits");
        $display("test register access done");
        for (int k = 0; k < 4; k++)
        begin
            wr(CTRL, {2'(k), 30'h0});
            repeat (512) @(negedge clk_sys);
            cnt(b, s, o);
            chk(32'(b), 32'(512 >> (2 * k + 2)), "baud rises");
            chk(32'(s), 32'h80, "serial rises");
            chk(32'(o), 32'h100, "clock out rises");
            chk(modeOut, TBL[6'h2D], "mode after baud change");
        end
        $display("test baud divide done");
        wr(CTRL, 32'h48000000);
        @(negedge clk_sys);
        cnt(b, s, o);
        chk(32'(o), 32'h0, "clock out disabled");
        $display("test clock out disable done");
        resetFor(6'h12);
        $display("test second reset done");
        results();
    end
    initial
    begin
        #2ms;
        miscompares++;
        results();
    end
endmodule // tb_ccm_clock_mode_config
